// file: rtl/flash_pwr_pkg.sv
package flash_pwr_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SUPPLY_TO_READ_TIME_US = 150;
  localparam int SUPPLY_TO_FULL_ACCESS_TIME_US = 150;
  localparam int PWRUP_CYC = SUPPLY_TO_FULL_ACCESS_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int RESET_PULSE_WIDTH_NS = 50;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_RECOVERY_TIME_FAST_NS = 40;
  localparam int FAST_REC_CYC = (RESET_RECOVERY_TIME_FAST_NS / CLK_PERIOD_NS < 1) ? 1 :
    RESET_RECOVERY_TIME_FAST_NS / CLK_PERIOD_NS;
  localparam int RESET_RECOVERY_TIME_SLOW_US = 30;
  localparam int SLOW_REC_CYC = RESET_RECOVERY_TIME_SLOW_US * 1000 / CLK_PERIOD_NS;
  localparam int SOFT_RESET_RECOVERY_TIME_NS = 90;
  localparam int SOFT_REC_CYC = (SOFT_RESET_RECOVERY_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
    SOFT_RESET_RECOVERY_TIME_NS / CLK_PERIOD_NS;
  localparam int DESELECT_TO_RESET_TIME_NS = 2;
  localparam int DESEL_TO_RST_CYC = (DESELECT_TO_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESCUE_GAP_NS = 50;
  localparam int GAP_CYC = (RESCUE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SCLK_HALF_CYC = 2'h2;
  localparam logic [4:0] CONFIRM_LEN_QUAD = 5'h07;
  localparam logic [4:0] CONFIRM_LEN_DUAL = 5'h0D;
  localparam logic [4:0] CONFIRM_LEN_EXT = 5'h19;
  localparam logic [4:0] FF_FRAME_LEN = 5'h08;
  localparam logic [4:0] CMD_FRAME_LEN = 5'h08;
  localparam logic [4:0] READ_FRAME_LEN = 5'h10;
  localparam logic [2:0] LAST_STEP = 3'h5;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_READ_FLAG = 8'h70;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_WRITE_NVCFG = 8'hB1;
  localparam logic [7:0] CMD_SUBSECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_WRITE_LOCK = 8'hE5;
  localparam logic [7:0] CMD_DEEP_PD = 8'hB9;
  localparam logic [7:0] CMD_RELEASE_DPD = 8'hAB;
  localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
  localparam logic [7:0] CMD_RESET_MEMORY = 8'h99;
  localparam int STAT_WIP_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  localparam int FLAG_READY_BIT = 7;
  typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} proto_t;
endpackage

// file: rtl/flash_link_if.sv
`timescale 1ns/100ps
interface flash_link_if;
  logic sclk;
  logic cs_n;
  logic rst_n;
  logic io0_o;
  logic io0_oe;
  logic io3_o;
  logic io3_oe;
  logic io1_o;
  logic io1_oe;
  // undriven lines float high through pull-ups
  wire io0 = io0_oe ? io0_o : 1'h1;
  wire io3 = io3_oe ? io3_o : 1'h1;
  wire io1 = io1_oe ? io1_o : 1'h1;
  modport host (output sclk, cs_n, rst_n, io0_o, io0_oe, io3_o, io3_oe, input io1);
  modport dev (input sclk, cs_n, rst_n, io0, io3, output io1_o, io1_oe);
endinterface

// file: rtl/flash_dev_end.sv
`timescale 1ns/100ps
// Function
// - supply low holds logic reset, ignores all
// - power-up phase accepts only status polls
// - power-up ends in standby, flags cleared
// - full access within 150 us of supply
// - host keeps select high during power transitions
// - boot may land in direct-read or other protocol
// - rescue part one: 7, 13, 25 clocks
// - rescue part two: all-ones byte, 8 clocks
// - rescue parts strictly in order
// - select high 50 ns between rescue frames
// - rescue ends extended protocol, direct-read off
// - host rewrites nonvolatile configuration after rescue
// - hardware reset pulse at least 50 ns
// - reset recovery by idle mode: 40 ns/30 us
// - reset recovery by running operation
// - reset during slow writes takes their duration
// - soft reset recovery 90 ns or 30 us; the short case counts 2 clocks, 80 ns
// - soft reset after slow writes takes duration
// - select high 2 ns before reset
// - line0 at confirmation clock keeps/ends direct-read
// - host follows rescue with reset enable, memory
module flash_dev_end
  import flash_pwr_pkg::*;
#(
  parameter int STATUS_WRITE_DURATION_US = 1000,
  parameter int NV_CONFIG_WRITE_DURATION_US = 1000,
  parameter int SUBSECTOR_ERASE_DURATION_US = 1000,
  parameter int ARRAY_PROGRAM_DURATION_US = 100
)
(
  input logic i_clk,
  input logic i_rst,
  input proto_t i_boot_proto,
  input logic i_boot_direct_read,
  flash_link_if.dev link,
  output logic o_powered_up,
  output logic o_standby,
  output logic o_busy,
  output logic o_deep_pd,
  output logic o_recovering,
  output logic o_direct_read,
  output proto_t o_proto,
  output logic o_write_enable,
  output logic o_write_lock,
  output logic o_lock_down,
  output logic o_cmd_reject
);
  localparam int STATUS_WRITE_CYC = STATUS_WRITE_DURATION_US * 1000 / CLK_PERIOD_NS;
  localparam int NV_CONFIG_WRITE_CYC = NV_CONFIG_WRITE_DURATION_US * 1000 / CLK_PERIOD_NS;
  localparam int SUBSECTOR_ERASE_CYC = SUBSECTOR_ERASE_DURATION_US * 1000 / CLK_PERIOD_NS;
  localparam int ARRAY_PROGRAM_CYC = ARRAY_PROGRAM_DURATION_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {ST_POWERUP, ST_STANDBY, ST_BUSY, ST_DEEP_PD, ST_RECOVER} state_t;
  typedef enum logic [2:0] {OP_NONE, OP_STATUS, OP_NVCFG, OP_SUBSECTOR, OP_ARRAY} op_t;

  function automatic logic [4:0] confirm_len(proto_t p);
    case (p)
      PROTO_QUAD: confirm_len = CONFIRM_LEN_QUAD;
      PROTO_DUAL: confirm_len = CONFIRM_LEN_DUAL;
      default: confirm_len = CONFIRM_LEN_EXT;
    endcase
  endfunction

  function automatic op_t op_of(logic [7:0] c);
    if (c == CMD_WRITE_STATUS)
      op_of = OP_STATUS;
    else if (c == CMD_WRITE_NVCFG)
      op_of = OP_NVCFG;
    else if (c == CMD_SUBSECTOR_ERASE)
      op_of = OP_SUBSECTOR;
    else if (c == CMD_PAGE_PROGRAM)
      op_of = OP_ARRAY;
    else
      op_of = OP_NONE;
  endfunction

  function automatic logic [31:0] op_dur(op_t op);
    case (op)
      OP_STATUS: op_dur = 32'(STATUS_WRITE_CYC);
      OP_NVCFG: op_dur = 32'(NV_CONFIG_WRITE_CYC);
      OP_SUBSECTOR: op_dur = 32'(SUBSECTOR_ERASE_CYC);
      default: op_dur = 32'(ARRAY_PROGRAM_CYC);
    endcase
  endfunction

  // recovery length tied to what the reset interrupted or followed
  function automatic logic [31:0] op_rec(op_t op);
    case (op)
      OP_STATUS: op_rec = 32'(STATUS_WRITE_CYC);
      OP_NVCFG: op_rec = 32'(NV_CONFIG_WRITE_CYC);
      OP_SUBSECTOR: op_rec = 32'(SUBSECTOR_ERASE_CYC);
      default: op_rec = 32'(SLOW_REC_CYC);
    endcase
  endfunction

  // link domain
  logic [4:0] bit_cnt_q;
  logic ones_q;
  logic [7:0] sh_in_q;
  logic [7:0] sh_out_q;
  logic out_on_q;
  proto_t proto_l1_q;
  proto_t proto_l2_q;
  logic dr_l1_q;
  logic dr_l2_q;
  logic [7:0] stat_l1_q;
  logic [7:0] stat_l2_q;
  logic [7:0] flag_l1_q;
  logic [7:0] flag_l2_q;
  logic xip_tgl_q;
  logic ext_tgl_q;
  logic cmd_tgl_q;
  logic [7:0] cmd_q;

  // system domain
  state_t state_q;
  op_t op_q;
  op_t last_op_q;
  logic [31:0] timer_q;
  logic [31:0] rst_low_q;
  logic wel_q;
  logic rst_en_q;
  logic wlock_q;
  logic ldown_q;
  proto_t proto_q;
  logic dr_q;
  logic reject_q;
  logic [2:0] xip_s_q;
  logic [2:0] ext_s_q;
  logic [2:0] cmd_s_q;
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_prev_q;
  proto_t boot_proto_s1_q;
  proto_t boot_proto_s2_q;
  logic boot_dr_s1_q;
  logic boot_dr_s2_q;
  logic [7:0] stat_byte;
  logic [7:0] flag_byte;
  op_t new_op;

  wire [4:0] bit_cnt_n = bit_cnt_q + 5'h01;
  wire ones_n = ones_q & link.io0 & link.io3;
  wire [7:0] cmd_n = {sh_in_q[6:0], link.io0};
  wire xip_hit = dr_l2_q & ones_n & (bit_cnt_n == confirm_len(proto_l2_q));
  wire ext_hit = !dr_l2_q & (proto_l2_q != PROTO_EXT) & ones_n & (bit_cnt_n == FF_FRAME_LEN);
  wire cmd_hit = !dr_l2_q & (proto_l2_q == PROTO_EXT) & (bit_cnt_n == CMD_FRAME_LEN);
  wire poll_rd = cmd_hit & ((cmd_n == CMD_READ_STATUS) | (cmd_n == CMD_READ_FLAG));

  // frame state dies with the frame, since the link clock stops between frames
  always_ff @(posedge link.sclk or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      bit_cnt_q <= '0;
      ones_q <= 1'h1;
      sh_in_q <= '0;
      sh_out_q <= '0;
      out_on_q <= 1'h0;
    end
    else
    begin
      if (bit_cnt_q != 5'h1F)
        bit_cnt_q <= bit_cnt_n;
      ones_q <= ones_n;
      sh_in_q <= cmd_n;
      if (poll_rd)
        sh_out_q <= (cmd_n == CMD_READ_STATUS) ? stat_l2_q : flag_l2_q;
      else
        sh_out_q <= {sh_out_q[6:0], 1'h0};
      if (poll_rd)
        out_on_q <= 1'h1;
    end
  end

  // status bytes change only on slow state moves, so per-bit sync is accepted
  always_ff @(posedge link.sclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      proto_l1_q <= PROTO_EXT;
      proto_l2_q <= PROTO_EXT;
      dr_l1_q <= 1'h0;
      dr_l2_q <= 1'h0;
      stat_l1_q <= '0;
      stat_l2_q <= '0;
      flag_l1_q <= '0;
      flag_l2_q <= '0;
      xip_tgl_q <= 1'h0;
      ext_tgl_q <= 1'h0;
      cmd_tgl_q <= 1'h0;
      cmd_q <= '0;
    end
    else
    begin
      proto_l1_q <= proto_q;
      proto_l2_q <= proto_l1_q;
      dr_l1_q <= dr_q;
      dr_l2_q <= dr_l1_q;
      stat_l1_q <= stat_byte;
      stat_l2_q <= stat_l1_q;
      flag_l1_q <= flag_byte;
      flag_l2_q <= flag_l1_q;
      if (!link.cs_n && xip_hit)
        xip_tgl_q <= !xip_tgl_q;
      if (!link.cs_n && ext_hit)
        ext_tgl_q <= !ext_tgl_q;
      if (!link.cs_n && cmd_hit)
      begin
        cmd_q <= cmd_n;
        cmd_tgl_q <= !cmd_tgl_q;
      end
    end
  end

  assign link.io1_o = sh_out_q[7];
  assign link.io1_oe = out_on_q & !link.cs_n;

  always_comb
  begin
    stat_byte = '0;
    stat_byte[STAT_WIP_BIT] = (state_q == ST_BUSY);
    stat_byte[STAT_WEL_BIT] = wel_q;
    flag_byte = '0;
    flag_byte[FLAG_READY_BIT] = (state_q != ST_BUSY);
  end

  // cmd_q was written with its toggle, so it is settled when the toggle lands
  wire cmd_ev = cmd_s_q[1] ^ cmd_s_q[2];
  wire xip_ev = xip_s_q[1] ^ xip_s_q[2];
  wire ext_ev = ext_s_q[1] ^ ext_s_q[2];
  wire gated = (state_q == ST_POWERUP) | (state_q == ST_RECOVER);
  wire is_poll = (cmd_q == CMD_READ_STATUS) | (cmd_q == CMD_READ_FLAG);
  wire cmd_take = cmd_ev & !gated;
  assign new_op = op_of(cmd_q);
  wire hw_rst = rst_s2_q & !rst_prev_q & (rst_low_q >= 32'(RESET_PULSE_CYC));
  wire soft_rst = cmd_take & rst_en_q & (cmd_q == CMD_RESET_MEMORY);
  wire [31:0] hw_rec = (state_q == ST_DEEP_PD) ? 32'(SLOW_REC_CYC) :
    (state_q == ST_BUSY) ? op_rec(op_q) : 32'(FAST_REC_CYC);
  wire [31:0] soft_rec = (state_q == ST_DEEP_PD) ? 32'(SLOW_REC_CYC) :
    (state_q == ST_BUSY) ? op_rec(op_q) :
    (last_op_q == OP_NONE) ? 32'(SOFT_REC_CYC) : op_rec(last_op_q);

  always_ff @(posedge i_clk)
  begin
    xip_s_q <= {xip_s_q[1:0], xip_tgl_q};
    ext_s_q <= {ext_s_q[1:0], ext_tgl_q};
    cmd_s_q <= {cmd_s_q[1:0], cmd_tgl_q};
    rst_s1_q <= link.rst_n;
    rst_s2_q <= rst_s1_q;
    rst_prev_q <= rst_s2_q;
    boot_proto_s1_q <= i_boot_proto;
    boot_proto_s2_q <= boot_proto_s1_q;
    boot_dr_s1_q <= i_boot_direct_read;
    boot_dr_s2_q <= boot_dr_s1_q;
    if (i_rst || rst_s2_q)
      rst_low_q <= '0;
    else if (rst_low_q != 32'hFFFFFFFF)
      rst_low_q <= rst_low_q + 32'h1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_q <= ST_POWERUP;
      timer_q <= 32'(PWRUP_CYC - 1);
      op_q <= OP_NONE;
      last_op_q <= OP_NONE;
      wel_q <= 1'h0;
      rst_en_q <= 1'h0;
      wlock_q <= 1'h0;
      ldown_q <= 1'h0;
      proto_q <= PROTO_EXT;
      dr_q <= 1'h0;
      reject_q <= 1'h0;
    end
    else
    begin
      reject_q <= cmd_ev & gated & !(is_poll && state_q == ST_POWERUP);
      if (hw_rst)
      begin
        state_q <= ST_RECOVER;
        timer_q <= hw_rec - 32'h1;
        op_q <= OP_NONE;
        last_op_q <= OP_NONE;
        wel_q <= 1'h0;
        rst_en_q <= 1'h0;
        proto_q <= boot_proto_s2_q;
        dr_q <= boot_dr_s2_q;
      end
      else if (soft_rst)
      begin
        state_q <= ST_RECOVER;
        timer_q <= soft_rec - 32'h1;
        op_q <= OP_NONE;
        last_op_q <= OP_NONE;
        wel_q <= 1'h0;
        rst_en_q <= 1'h0;
      end
      else
      begin
        if (xip_ev && !gated)
          dr_q <= 1'h0;
        if (ext_ev && !gated)
          proto_q <= PROTO_EXT;
        if (cmd_take && !is_poll)
          rst_en_q <= (cmd_q == CMD_RESET_ENABLE);
        case (state_q)
          ST_POWERUP:
          begin
            if (timer_q == '0)
            begin
              state_q <= ST_STANDBY;
              proto_q <= boot_proto_s2_q;
              dr_q <= boot_dr_s2_q;
            end
            else
              timer_q <= timer_q - 32'h1;
          end
          ST_STANDBY:
          begin
            if (cmd_take)
            begin
              if (cmd_q == CMD_WRITE_ENABLE)
                wel_q <= 1'h1;
              else if (cmd_q == CMD_WRITE_DISABLE)
                wel_q <= 1'h0;
              else if (cmd_q == CMD_DEEP_PD)
                state_q <= ST_DEEP_PD;
              else if (cmd_q == CMD_WRITE_LOCK && wel_q)
              begin
                wlock_q <= 1'h1;
                ldown_q <= wlock_q;
                wel_q <= 1'h0;
              end
              else if (new_op != OP_NONE && wel_q)
              begin
                state_q <= ST_BUSY;
                op_q <= new_op;
                timer_q <= op_dur(new_op) - 32'h1;
              end
            end
          end
          ST_BUSY:
          begin
            if (timer_q == '0)
            begin
              state_q <= ST_STANDBY;
              last_op_q <= op_q;
              op_q <= OP_NONE;
              wel_q <= 1'h0;
            end
            else
              timer_q <= timer_q - 32'h1;
          end
          ST_DEEP_PD:
          begin
            if (cmd_take && cmd_q == CMD_RELEASE_DPD)
              state_q <= ST_STANDBY;
          end
          default:
          begin
            if (timer_q == '0)
              state_q <= ST_STANDBY;
            else
              timer_q <= timer_q - 32'h1;
          end
        endcase
      end
    end
  end

  assign o_powered_up = (state_q != ST_POWERUP);
  assign o_standby = (state_q == ST_STANDBY);
  assign o_busy = (state_q == ST_BUSY);
  assign o_deep_pd = (state_q == ST_DEEP_PD);
  assign o_recovering = (state_q == ST_RECOVER);
  assign o_direct_read = dr_q;
  assign o_proto = proto_q;
  assign o_write_enable = wel_q;
  assign o_write_lock = wlock_q;
  assign o_lock_down = ldown_q;
  assign o_cmd_reject = reject_q;
endmodule

// file: rtl/flash_host_end.sv
`timescale 1ns/100ps
module flash_host_end
  import flash_pwr_pkg::*;
(
  input logic i_clk,
  input logic i_rst,
  input logic i_rescue,
  input logic i_cmd_valid,
  input logic [7:0] i_cmd,
  input logic i_hw_reset,
  output logic o_ready,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  flash_link_if.host link
);
  typedef enum logic [2:0] {H_POWERUP, H_IDLE, H_FRAME, H_GAP, H_RST_SETUP, H_RST_LOW, H_WAIT} hstate_t;

  function automatic logic [4:0] step_len(logic [2:0] s);
    case (s)
      3'h0: step_len = CONFIRM_LEN_QUAD;
      3'h1: step_len = CONFIRM_LEN_DUAL;
      3'h2: step_len = CONFIRM_LEN_EXT;
      default: step_len = FF_FRAME_LEN;
    endcase
  endfunction

  function automatic logic [15:0] step_tx(logic [2:0] s);
    if (s <= 3'h3)
      step_tx = 16'hFFFF;
    else if (s == 3'h4)
      step_tx = {CMD_RESET_ENABLE, 8'h00};
    else
      step_tx = {CMD_RESET_MEMORY, 8'h00};
  endfunction

  hstate_t st_q;
  logic [31:0] timer_q;
  logic [2:0] step_q;
  logic in_seq_q;
  logic [4:0] len_q;
  logic [4:0] edge_q;
  logic [15:0] tx_q;
  logic rd_q;
  logic [1:0] div_q;
  logic sclk_q;
  logic cs_n_q;
  logic rst_n_q;
  logic io1_s1_q;
  logic io1_s2_q;
  logic [7:0] rd_data_q;
  logic rd_valid_q;

  wire is_read = (i_cmd == CMD_READ_STATUS) | (i_cmd == CMD_READ_FLAG);
  wire half_end = (div_q == SCLK_HALF_CYC - 2'h1);
  wire [2:0] next_step = step_q + 3'h1;

  always_ff @(posedge i_clk)
  begin
    io1_s1_q <= link.io1;
    io1_s2_q <= io1_s1_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_q <= H_POWERUP;
      timer_q <= 32'(PWRUP_CYC - 1);
      step_q <= '0;
      in_seq_q <= 1'h0;
      len_q <= '0;
      edge_q <= '0;
      tx_q <= '0;
      rd_q <= 1'h0;
      div_q <= '0;
      sclk_q <= 1'h0;
      cs_n_q <= 1'h1;
      rst_n_q <= 1'h1;
      rd_data_q <= '0;
      rd_valid_q <= 1'h0;
    end
    else
    begin
      rd_valid_q <= 1'h0;
      case (st_q)
        H_POWERUP:
        begin
          if (timer_q == '0)
            st_q <= H_IDLE;
          else
            timer_q <= timer_q - 32'h1;
        end
        H_IDLE:
        begin
          div_q <= '0;
          edge_q <= '0;
          if (i_hw_reset)
          begin
            st_q <= H_RST_SETUP;
            timer_q <= 32'(DESEL_TO_RST_CYC - 1);
          end
          else if (i_rescue)
          begin
            st_q <= H_FRAME;
            cs_n_q <= 1'h0;
            in_seq_q <= 1'h1;
            step_q <= '0;
            len_q <= step_len(3'h0);
            tx_q <= step_tx(3'h0);
            rd_q <= 1'h0;
          end
          else if (i_cmd_valid)
          begin
            st_q <= H_FRAME;
            cs_n_q <= 1'h0;
            in_seq_q <= 1'h0;
            len_q <= is_read ? READ_FRAME_LEN : CMD_FRAME_LEN;
            tx_q <= {i_cmd, 8'h00};
            rd_q <= is_read;
          end
        end
        H_FRAME:
        begin
          div_q <= half_end ? 2'h0 : div_q + 2'h1;
          if (half_end && !sclk_q)
          begin
            sclk_q <= 1'h1;
            edge_q <= edge_q + 5'h01;
            if (rd_q && edge_q >= CMD_FRAME_LEN)
              rd_data_q <= {rd_data_q[6:0], io1_s2_q};
          end
          else if (half_end)
          begin
            sclk_q <= 1'h0;
            if (edge_q == len_q)
            begin
              cs_n_q <= 1'h1;
              st_q <= H_GAP;
              timer_q <= 32'(GAP_CYC - 1);
              rd_valid_q <= rd_q;
            end
            else
              tx_q <= {tx_q[14:0], 1'h0};
          end
        end
        H_GAP:
        begin
          div_q <= '0;
          edge_q <= '0;
          if (timer_q != '0)
            timer_q <= timer_q - 32'h1;
          else if (in_seq_q && step_q != LAST_STEP)
          begin
            st_q <= H_FRAME;
            cs_n_q <= 1'h0;
            step_q <= next_step;
            len_q <= step_len(next_step);
            tx_q <= step_tx(next_step);
          end
          else if (in_seq_q)
          begin
            st_q <= H_WAIT;
            in_seq_q <= 1'h0;
            timer_q <= 32'(SLOW_REC_CYC - 1);
          end
          else
            st_q <= H_IDLE;
        end
        H_RST_SETUP:
        begin
          if (timer_q == '0)
          begin
            st_q <= H_RST_LOW;
            rst_n_q <= 1'h0;
            timer_q <= 32'(RESET_PULSE_CYC - 1);
          end
          else
            timer_q <= timer_q - 32'h1;
        end
        H_RST_LOW:
        begin
          if (timer_q == '0)
          begin
            st_q <= H_WAIT;
            rst_n_q <= 1'h1;
            timer_q <= 32'(SLOW_REC_CYC - 1);
          end
          else
            timer_q <= timer_q - 32'h1;
        end
        default:
        begin
          if (timer_q == '0)
            st_q <= H_IDLE;
          else
            timer_q <= timer_q - 32'h1;
        end
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.rst_n = rst_n_q;
  assign link.io0_o = tx_q[15];
  assign link.io0_oe = !cs_n_q;
  assign link.io3_o = 1'h1;
  assign link.io3_oe = !cs_n_q;
  assign o_ready = (st_q == H_IDLE);
  assign o_rd_valid = rd_valid_q;
  assign o_rd_data = rd_data_q;
endmodule

// file: verif/flash_pwr_checker.sv
`timescale 1ns/100ps
module flash_pwr_checker
  import flash_pwr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic rst_n,
  input wire logic io0,
  input wire logic io3
);
  logic sclk_q;
  logic cs_q;
  logic ones_q;
  logic [5:0] cnt_q;
  logic [5:0] last_q;
  wire rise = sclk && !sclk_q && !cs_n;
  wire frame_end = cs_n && !cs_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ones_q survives a frame only if both lines stayed high at every rise
  always_ff @(posedge i_clk)
  begin
    sclk_q <= sclk;
    cs_q <= cs_n;
    cnt_q <= cs_n ? 6'h00 : cnt_q + {5'h00, rise};
    ones_q <= cs_n | (ones_q & ~(rise & ~(io0 & io3)));
    last_q <= i_rst ? 6'h00 : (frame_end ? cnt_q : last_q);
  end
  reset_idle_a: assert property (disable iff (1'b0) i_rst && $past(i_rst) |-> cs_n && rst_n && !sclk)
    else $error("link not idle in reset");
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("clock moves while deselected");
  gap_a: assert property ($rose(cs_n) |-> cs_n [*2])
    else $error("deselect gap too short");
  pulse_a: assert property ($fell(rst_n) |-> !rst_n [*2])
    else $error("reset pulse too short");
  desel_a: assert property ($fell(rst_n) |-> cs_n && $past(cs_n))
    else $error("reset while selected");
  frame_len_a: assert property ($rose(cs_n) |-> cnt_q inside {6'h07, 6'h08, 6'h0D, 6'h10, 6'h19})
    else $error("bad frame length");
  order_a: assert property ($rose(cs_n) && ones_q && cnt_q == 6'h08 |-> last_q == 6'h19)
    else $error("ones byte out of order");
  steps_a: assert property ($rose(cs_n) && ones_q && (cnt_q inside {6'h0D, 6'h19})
    |-> last_q == ((cnt_q == 6'h0D) ? 6'h07 : 6'h0D))
    else $error("rescue frames out of order");
  cover property ($rose(cs_n) && ones_q && cnt_q == 6'h08);
  cover property ($fell(rst_n));
  cover property ($rose(cs_n) && cnt_q == 6'h10);
endmodule

// file: verif/tb_flash_power_on_and_recovery.sv
`timescale 1ns/100ps
module tb_flash_power_on_and_recovery;
  import flash_pwr_pkg::*;
  logic i_clk = 1'b0;
  // starts low so the first raise is a real edge for the async link flops
  logic i_rst = 1'b0;
  logic i_rescue = 1'b0;
  logic i_cmd_valid = 1'b0;
  logic [7:0] i_cmd = 8'h00;
  logic i_hw_reset = 1'b0;
  proto_t boot_proto = PROTO_QUAD;
  logic boot_dr = 1'b1;
  logic ready, powered_up, standby, busy, direct_read, write_enable, write_lock, lock_down, deep_pd, recovering;
  logic [7:0] rd_data;
  proto_t proto;
  proto_t tbl [3] = '{PROTO_EXT, PROTO_DUAL, PROTO_QUAD};
  logic [31:0] seed = 32'hCF750BE9;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  flash_link_if link ();
  flash_dev_end #(.STATUS_WRITE_DURATION_US(1), .NV_CONFIG_WRITE_DURATION_US(1),
    .SUBSECTOR_ERASE_DURATION_US(1), .ARRAY_PROGRAM_DURATION_US(1)) i_flash_dev_end (
    .i_clk(i_clk), .i_rst(i_rst), .i_boot_proto(boot_proto), .i_boot_direct_read(boot_dr), .link(link),
    .o_powered_up(powered_up), .o_standby(standby), .o_busy(busy), .o_deep_pd(deep_pd), .o_recovering(recovering),
    .o_direct_read(direct_read), .o_proto(proto), .o_write_enable(write_enable), .o_write_lock(write_lock),
    .o_lock_down(lock_down), .o_cmd_reject());
  flash_host_end i_flash_host_end (.i_clk(i_clk), .i_rst(i_rst), .i_rescue(i_rescue), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .i_hw_reset(i_hw_reset), .o_ready(ready), .o_rd_valid(), .o_rd_data(rd_data), .link(link));
  flash_pwr_checker i_flash_pwr_checker (.i_clk(i_clk), .i_rst(i_rst), .sclk(link.sclk), .cs_n(link.cs_n),
    .rst_n(link.rst_n), .io0(link.io0), .io3(link.io3));
  always #20 i_clk = ~i_clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic [7:0] exp_status(input logic wel);
    return {6'h00, wel, 1'h0};
  endfunction
  task close_out;
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // power-up alone takes 3750 cycles, so the bound sits above it
  task automatic wait_ready;
    for (int i = 0; i < 5000 && ready !== 1'b1; i++)
      @(negedge i_clk);
    chk1(ready, 1'h1);
  endtask
  task automatic req(input int k, input logic [7:0] c);
    wait_ready();
    i_cmd = c;
    i_cmd_valid = (k == 0);
    i_rescue = (k == 1);
    i_hw_reset = (k == 2);
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
    i_rescue = 1'b0;
    i_hw_reset = 1'b0;
    wait_ready();
  endtask
  task automatic power_up(input proto_t p, input logic dr);
    i_rst = 1'b1;
    boot_proto = p;
    boot_dr = dr;
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (100) @(negedge i_clk);
    chk1(powered_up, 1'h0);
    wait_ready();
    chk1(powered_up, 1'h1);
    chk1(standby, 1'h1);
    chk1(busy, 1'h0);
    chk1(write_enable, 1'h0);
    chk1(write_lock, 1'h0);
    chk1(lock_down, 1'h0);
    chk1(direct_read, dr);
    chk8({6'h00, proto}, {6'h00, p});
  endtask
  task automatic rescue_check;
    req(1, 8'h00);
    chk1(direct_read, 1'h0);
    chk8({6'h00, proto}, {6'h00, PROTO_EXT});
    req(0, CMD_READ_STATUS);
    chk8(rd_data, exp_status(1'h0));
    req(0, CMD_WRITE_ENABLE);
    req(0, CMD_WRITE_NVCFG);
    chk1(busy, 1'h1);
  endtask
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_fail++;
      close_out();
    end
  end
  initial
  begin
    #1;
    power_up(PROTO_QUAD, 1'b1);
    rescue_check();
    req(0, CMD_WRITE_ENABLE);
    req(0, CMD_READ_STATUS);
    chk8(rd_data, exp_status(1'h1));
    chk1(write_enable, 1'h1);
    req(0, CMD_WRITE_LOCK);
    req(0, CMD_WRITE_ENABLE);
    req(0, CMD_WRITE_LOCK);
    chk1(write_lock, 1'h1);
    chk1(lock_down, 1'h1);
    req(0, CMD_READ_FLAG);
    chk1(rd_data[FLAG_READY_BIT], 1'h1);
    req(0, CMD_DEEP_PD);
    chk1(deep_pd, 1'h1);
    req(0, CMD_RELEASE_DPD);
    chk1(standby, 1'h1);
    req(0, CMD_WRITE_ENABLE);
    req(0, CMD_PAGE_PROGRAM);
    chk1(busy, 1'h1);
    // reset in mid-program takes the slow recovery, so it outlasts the host wait
    req(2, 8'h00);
    chk1(recovering, 1'h1);
    req(2, 8'h00);
    chk1(direct_read, 1'h1);
    chk8({6'h00, proto}, {6'h00, PROTO_QUAD});
    for (int i = 0; i < 3; i++)
    begin
      seed = xs(seed);
      power_up(tbl[i], seed[4]);
      rescue_check();
    end
    close_out();
  end
endmodule
